//--- rtl/psv_pkg.sv
// What this block does
// - Ten-bit program counter addresses a 1K word program memory of 13-bit words.
// - Any reset loads the program counter with 3FFh and fetching starts there.
// - An accepted hardware interrupt redirects execution to address 008h.
// - A software interrupt jumps to address 002h, apart from the hardware entry.
// - Call and jump reach any program address directly, without page selection.
// - Instructions take one cycle; program flow changes take two cycles.
// - A five entry hardware return stack serves calls and returns.
// - The decoder serves 42 instructions, each a single 13-bit word.
// - Interrupt sources are counter overflow, external pin and port B change.
// - Sleep ends on an external interrupt pin event or a port B change.
// - Shared pin resets the device while low; its weak pull-up stays on.
// - In RC modes, when chosen, the oscillator output toggles at cycle rate.
// - A 20 MHz input gives a 100 ns cycle; logic is fully static.
// - Program counter low byte is reachable as a data memory location.
// - On a low byte write, the upper two counter bits come from the high byte buffer.
// - The counter increments by one each cycle unless an instruction or an accepted interrupt changes it.
package psv_pkg;
  localparam int          PC_W         = 10;
  localparam int          WORD_W       = 13;
  localparam int          STACK_DEPTH  = 5;
  localparam int          SRC_N        = 3;
  localparam logic [9:0]  RESET_VECTOR = 10'h3ff;
  localparam logic [9:0]  HW_INT_VEC   = 10'h008;
  localparam logic [9:0]  SW_INT_VEC   = 10'h002;
  localparam int          OSC_MHZ      = 20;
  localparam int          INSTR_NS     = 100;
  localparam int          CYCLE_CLKS   = INSTR_NS * OSC_MHZ / 1000;
  localparam logic [2:0]  OP_CALL      = 3'h4;
  localparam logic [2:0]  OP_GOTO      = 3'h5;
  localparam logic [12:0] OP_RET       = 13'h0010;
  localparam logic [12:0] OP_RETI      = 13'h0011;
  localparam logic [12:0] OP_SWI       = 13'h0012;
  localparam logic [12:0] OP_SLEEP     = 13'h0003;
  localparam logic [12:0] OP_NOP       = 13'h0000;
  localparam int          SRC_TICK     = 0;
  localparam int          SRC_PORTB    = 1;
  localparam int          SRC_EXT      = 2;
  typedef enum logic [1:0] {
    PSV_RUN   = 2'b01,
    PSV_SLEEP = 2'b10
  } psv_state_t;
endpackage

//--- rtl/psv_sequencer.sv
`timescale 1ns/100ps
module psv_sequencer
  import psv_pkg::*;
#(
  parameter int STACK_N = STACK_DEPTH
) (
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              reset_in_n,
  input  wire logic              rst_pin_mode,
  input  wire logic [WORD_W-1:0] imem_data,
  input  wire logic              pcl_wr,
  input  wire logic [7:0]        pcl_wdata,
  input  wire logic              pc_high_buffer_wr,
  input  wire logic [1:0]        pc_high_buffer_wdata,
  input  wire logic              skip_req,
  input  wire logic              gie,
  input  wire logic [SRC_N-1:0]  int_enable,
  input  wire logic [SRC_N-1:0]  int_flag,
  input  wire logic              ext_int_event,
  input  wire logic              portb_change_event,
  input  wire logic              rc_mode,
  input  wire logic              cycle_rate_out_select,
  output logic [PC_W-1:0]        imem_addr,
  output logic [WORD_W-1:0]      instr_word,
  output logic                   instr_valid,
  output logic [7:0]             pc_low_byte,
  output logic [1:0]             pc_high_buffer,
  output logic                   int_ack,
  output logic                   sleeping,
  output logic                   osc_out_pin_o,
  output logic                   osc_out_pin_oe,
  output logic                   reset_pin_pullup
);
  // The phase counter is four bits wide, so longer instruction cycles cannot be served.
  if (STACK_N < 2 || CYCLE_CLKS < 2 || CYCLE_CLKS > 16) begin : g_bad_cfg
    $error("psv_sequencer: unsupported parameters");
  end

  logic [PC_W-1:0]   pc_q, pc_d, ex_pc_q;
  logic [WORD_W-1:0] ir_q;
  logic              ir_valid_q;
  logic [PC_W-1:0]   stk_q [STACK_N];
  logic [1:0]        pc_high_buffer_q;
  logic [3:0]        phase_q;
  psv_state_t        state_q;
  logic              int_ack_q, osc_q, osc_oe_q, pullup_q;

  // The pin reset is sampled with the clock, so it acts like the core reset.
  wire sys_rst   = reset | (rst_pin_mode & ~reset_in_n);
  wire cyc_en    = (phase_q == 4'(CYCLE_CLKS - 1)) && (state_q == PSV_RUN);
  // Only the program flow opcodes and sleep are resolved here; the data path decodes the rest.
  wire is_call   = ir_valid_q && (ir_q[12:10] == OP_CALL);
  wire is_goto   = ir_valid_q && (ir_q[12:10] == OP_GOTO);
  wire is_ret    = ir_valid_q && (ir_q == OP_RET || ir_q == OP_RETI);
  wire is_swi    = ir_valid_q && (ir_q == OP_SWI);
  wire is_sleep  = ir_valid_q && (ir_q == OP_SLEEP);
  wire int_pend  = gie && |(int_enable & int_flag);
  wire int_take  = cyc_en && int_pend && ir_valid_q;
  wire jumps     = is_call | is_goto | is_ret | is_swi | pcl_wr;
  wire flow_chg  = cyc_en && !int_take && (jumps || (ir_valid_q && skip_req));
  wire push      = int_take || (cyc_en && is_call) || (cyc_en && is_swi);
  wire pop       = cyc_en && !int_take && is_ret;
  wire wake      = ext_int_event | portb_change_event;
  wire [PC_W-1:0] push_val = int_take ? ex_pc_q : ex_pc_q + 10'h001;

  always_comb begin
    pc_d = pc_q + 10'h001;
    if (int_take) begin
      pc_d = HW_INT_VEC;
    end else if (is_swi) begin
      pc_d = SW_INT_VEC;
    end else if (is_call || is_goto) begin
      pc_d = ir_q[PC_W-1:0];
    end else if (is_ret) begin
      pc_d = stk_q[0];
    end else if (pcl_wr) begin
      pc_d = {pc_high_buffer_q, pcl_wdata};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || phase_q == 4'(CYCLE_CLKS - 1)) begin
      phase_q <= 4'h0;
    end else begin
      phase_q <= phase_q + 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pc_q       <= RESET_VECTOR;
      ex_pc_q    <= RESET_VECTOR;
      ir_q       <= OP_NOP;
      ir_valid_q <= 1'b0;
    end else if (cyc_en) begin
      pc_q       <= pc_d;
      ex_pc_q    <= pc_q;
      ir_q       <= imem_data;
      ir_valid_q <= !(flow_chg || int_take);
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < STACK_N; i++) begin
        stk_q[i] <= RESET_VECTOR;
      end
    end else if (push) begin
      stk_q[0] <= push_val;
      for (int i = 1; i < STACK_N; i++) begin
        stk_q[i] <= stk_q[i-1];
      end
    end else if (pop) begin
      for (int i = 0; i < STACK_N - 1; i++) begin
        stk_q[i] <= stk_q[i+1];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pc_high_buffer_q <= 2'h0;
    end else if (pc_high_buffer_wr) begin
      pc_high_buffer_q <= pc_high_buffer_wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= PSV_RUN;
    end else begin
      case (state_q)
        PSV_RUN: begin
          if (cyc_en && !int_take && is_sleep) begin
            state_q <= PSV_SLEEP;
          end
        end
        PSV_SLEEP: begin
          if (wake) begin
            state_q <= PSV_RUN;
          end
        end
        default: state_q <= PSV_RUN;
      endcase
    end
  end

  // The RC output is a square wave of one instruction period; the divider runs on in sleep.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      int_ack_q <= 1'b0;
      osc_q     <= 1'b0;
      osc_oe_q  <= 1'b0;
    end else begin
      int_ack_q <= int_take;
      osc_q     <= (rc_mode && cycle_rate_out_select) ? (phase_q < 4'(CYCLE_CLKS / 2)) : 1'b0;
      osc_oe_q  <= rc_mode && cycle_rate_out_select;
    end
  end

  // No reset here: the pull-up must stay on while the pin itself holds the core in reset.
  always_ff @(posedge core_clk) begin
    pullup_q <= rst_pin_mode;
  end

  assign imem_addr        = pc_q;
  assign instr_word       = ir_q;
  assign instr_valid      = ir_valid_q;
  assign pc_low_byte      = pc_q[7:0];
  assign pc_high_buffer   = pc_high_buffer_q;
  assign int_ack          = int_ack_q;
  // One-hot state: bit 1 is the sleep state, so the output leaves the flip-flop directly.
  assign sleeping         = state_q[1];
  assign osc_out_pin_o    = osc_q;
  assign osc_out_pin_oe   = osc_oe_q;
  assign reset_pin_pullup = pullup_q;

  property p_reset_vec;
    @(posedge core_clk) sys_rst |=> (pc_q == 10'h3ff) && !ir_valid_q;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("pc not at reset vector");

  property p_hw_vec;
    @(posedge core_clk) disable iff (sys_rst) int_take |=> pc_q == 10'h008 && int_ack_q;
  endproperty
  a_hw_vec: assert property (p_hw_vec) else $error("interrupt did not reach 008h");

  property p_sw_vec;
    @(posedge core_clk) disable iff (sys_rst) (cyc_en && is_swi && !int_take) |=> pc_q == 10'h002;
  endproperty
  a_sw_vec: assert property (p_sw_vec) else $error("software interrupt did not reach 002h");

  property p_goto;
    @(posedge core_clk) disable iff (sys_rst)
      (cyc_en && is_goto && !int_take) |=> pc_q == $past(ir_q[9:0]);
  endproperty
  a_goto: assert property (p_goto) else $error("jump target not loaded");

  property p_two_cycle;
    @(posedge core_clk) disable iff (sys_rst) flow_chg |=> !ir_valid_q ##2 ir_valid_q;
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("flow change not two cycles");

  property p_increment;
    @(posedge core_clk) disable iff (sys_rst)
      (cyc_en && !int_take && !jumps) |=> pc_q == $past(pc_q) + 10'h001;
  endproperty
  a_increment: assert property (p_increment) else $error("pc did not increment");

  property p_int_push;
    @(posedge core_clk) disable iff (sys_rst) int_take |=> stk_q[0] == $past(ex_pc_q);
  endproperty
  a_int_push: assert property (p_int_push) else $error("interrupt return address wrong");

  property p_call_ret;
    @(posedge core_clk) disable iff (sys_rst)
      (cyc_en && is_call && !int_take) |=> stk_q[0] == $past(ex_pc_q) + 10'h001;
  endproperty
  a_call_ret: assert property (p_call_ret) else $error("call return address wrong");

  property p_wake;
    @(posedge core_clk) disable iff (sys_rst) (sleeping && wake) |=> !sleeping;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake from sleep");

  property p_cycle_rate_out;
    @(posedge core_clk) disable iff (sys_rst)
      (rc_mode && cycle_rate_out_select && !sleeping && phase_q == 4'h0) |=> osc_q ##1 !osc_q;
  endproperty
  a_cycle_rate_out: assert property (p_cycle_rate_out) else $error("rc output not at cycle rate");

  property p_pullup;
    @(posedge core_clk) rst_pin_mode |=> reset_pin_pullup;
  endproperty
  a_pullup: assert property (p_pullup) else $error("reset pin pull-up dropped");
endmodule

//--- testbench/psv_pmem.sv
`timescale 1ns/100ps
module psv_pmem
  import psv_pkg::*;
(
  input  wire logic [PC_W-1:0]   addr,
  output logic      [WORD_W-1:0] data
);
  logic [WORD_W-1:0] mem [1024];
  // Reads are combinational because the sequencer samples the word on its fetch edge.
  assign data = mem[addr];
endmodule

//--- testbench/program_sequencer_vectors_test.sv
`timescale 1ns/100ps
module program_sequencer_vectors_test
  import psv_pkg::*;
;
  logic              core_clk, reset, reset_in_n, rst_pin_mode, pcl_wr, pc_high_buffer_wr, gie;
  logic              ext_int_event, portb_change_event, rc_mode, cycle_rate_out_select, int_ack;
  logic              sleeping, osc_out_pin_o, osc_out_pin_oe, reset_pin_pullup, ob;
  logic              skip_req, instr_valid;
  logic [7:0]        pcl_wdata, pc_low_byte, lb;
  logic [1:0]        pc_high_buffer_wdata, pc_high_buffer, hb;
  logic [2:0]        int_enable, int_flag;
  logic [WORD_W-1:0] imem_data, instr_word;
  logic [PC_W-1:0]   imem_addr, a, last_pc = RESET_VECTOR;
  logic [PC_W-1:0]   q [$];
  logic [PC_W-1:0]   seq [12] = '{10'h000, 10'h100, 10'h101, 10'h200, 10'h201, 10'h202,
                                  10'h101, 10'h102, 10'h002, 10'h003, 10'h102, 10'h103};
  int                n_mismatch = 0, comparisons = 0, k, n;

  psv_pmem pm (.addr(imem_addr), .data(imem_data));
  psv_sequencer dut (.core_clk, .reset, .reset_in_n, .rst_pin_mode, .imem_data, .pcl_wr,
    .pcl_wdata, .pc_high_buffer_wr, .pc_high_buffer_wdata, .skip_req, .gie, .int_enable, .int_flag,
    .ext_int_event, .portb_change_event, .rc_mode, .cycle_rate_out_select, .imem_addr,
    .instr_word, .instr_valid, .pc_low_byte, .pc_high_buffer, .int_ack, .sleeping,
    .osc_out_pin_o, .osc_out_pin_oe, .reset_pin_pullup);

  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    #20000;
    n_mismatch++;
    complete_run();
  end

  // Every new program address is one fetch; an unchanged address cannot be told apart.
  // Looking just after the edge keeps this ahead of notes queued at the falling edge.
  always @(posedge core_clk) begin
    #1;
    if (!reset && imem_addr !== last_pc) begin
      last_pc = imem_addr;
      if (q.size() > 0) chk(13'(imem_addr), 13'(q.pop_front()));
    end
  end

  initial begin
    {reset, reset_in_n, rst_pin_mode} = 3'h7;
    {pcl_wr, pc_high_buffer_wr, gie, ext_int_event, portb_change_event, rc_mode, cycle_rate_out_select} = '0;
    skip_req = 1'b0;
    {pcl_wdata, pc_high_buffer_wdata, int_enable, int_flag} = '0;
    void'($urandom(30992));
    for (int i = 0; i < 1024; i++) pm.mem[i] = OP_NOP;
    pm.mem[10'h3ff] = {OP_GOTO, 10'h100};
    pm.mem[10'h100] = {OP_CALL, 10'h200};
    pm.mem[10'h201] = OP_RET;
    pm.mem[10'h101] = OP_SWI;
    pm.mem[10'h002] = OP_RETI;
    pm.mem[10'h102] = OP_SLEEP;
    pm.mem[10'h008] = OP_RETI;
    foreach (seq[i]) q.push_back(seq[i]);
    repeat (8) @(negedge core_clk);
    reset = 1'b0;
    chk(13'(imem_addr), 13'(RESET_VECTOR));
    chk(13'(reset_pin_pullup), 13'h1);
    for (k = 0; k < 8 && instr_valid !== 1'b1; k++) @(negedge core_clk);
    chk(13'(instr_word), {OP_GOTO, 10'h100});
    for (k = 0; k < 80 && sleeping !== 1'b1; k++) @(negedge core_clk);
    chk(13'(sleeping), 13'h1);
    a = imem_addr;
    repeat (6) @(negedge core_clk);
    chk(13'(imem_addr), 13'(a));
    {ext_int_event, portb_change_event} = 2'($urandom_range(1, 2));
    for (k = 0; k < 20 && sleeping !== 1'b0; k++) @(negedge core_clk);
    {ext_int_event, portb_change_event} = 2'h0;
    chk(13'(sleeping), 13'h0);
    gie = 1'b1;
    int_enable = 3'h7;
    for (int s = 0; s < SRC_N; s++) begin
      int_flag = 3'(1 << s);
      for (k = 0; k < 40 && int_ack !== 1'b1; k++) begin
        a = imem_addr;
        @(negedge core_clk);
      end
      chk(13'(int_ack), 13'h1);
      chk(13'(imem_addr), 13'(HW_INT_VEC));
      int_flag = 3'h0;
      // The pushed address is the one whose word was fetched but not executed.
      q.push_back(HW_INT_VEC + 10'h1);
      q.push_back(a - 10'h1);
      for (k = 0; k < 40 && q.size() > 0; k++) @(negedge core_clk);
    end
    gie = 1'b0;
    repeat (2) @(negedge core_clk);
    skip_req = 1'b1;
    for (k = 0; k < 4 && instr_valid !== 1'b0; k++) @(negedge core_clk);
    skip_req = 1'b0;
    chk(13'(instr_valid), 13'h0);
    repeat (2) @(negedge core_clk);
    chk(13'(instr_valid), 13'h1);
    hb = 2'($urandom_range(3));
    lb = 8'($urandom_range(255));
    pc_high_buffer_wdata = hb;
    pc_high_buffer_wr = 1'b1;
    @(negedge core_clk);
    pc_high_buffer_wr = 1'b0;
    chk(13'(pc_high_buffer), 13'(hb));
    pcl_wdata = lb;
    pcl_wr = 1'b1;
    repeat (2) @(negedge core_clk);
    pcl_wr = 1'b0;
    chk(13'(imem_addr), 13'({hb, lb}));
    chk(13'(pc_low_byte), 13'(lb));
    {rc_mode, cycle_rate_out_select} = 2'h3;
    repeat (2) @(negedge core_clk);
    n = 0;
    ob = osc_out_pin_o;
    repeat (8) begin
      @(negedge core_clk);
      if (osc_out_pin_o !== ob) n++;
      ob = osc_out_pin_o;
    end
    chk(13'(osc_out_pin_oe), 13'h1);
    chk(13'(n), 13'(8 / (CYCLE_CLKS / 2)));
    reset_in_n = 1'b0;
    repeat (2) @(negedge core_clk);
    chk(13'(imem_addr), 13'(RESET_VECTOR));
    chk(13'(reset_pin_pullup), 13'h1);
    reset_in_n = 1'b1;
    chk(13'(q.size()), 13'h0);
    complete_run();
  end
endmodule
